//--- logic/e1_pm_pkg.sv
`default_nettype none
package e1_pm_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_OVERFLOW_LATCH  = 5'h16;
  localparam logic [4:0] OFS_LOST_SYNC_COUNT = 5'h17;
  localparam logic [4:0] OFS_ALIGN_BIT_COUNT = 5'h18;
  localparam logic [4:0] OFS_RAI_CRC_FLAGS   = 5'h19;
  localparam logic [4:0] OFS_ERR_ALIGN_COUNT = 5'h1a;
  localparam logic [4:0] OFS_ALARM_LATCH     = 5'h1b;
  localparam logic [4:0] OFS_VIOLATION_HIGH  = 5'h1c;
  localparam logic [4:0] OFS_VIOLATION_LOW   = 5'h1d;
  localparam logic [4:0] OFS_CRC4_HIGH       = 5'h1e;
  localparam logic [4:0] OFS_CRC4_LOW        = 5'h1f;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_REMOTE_ALARM    = 7;
  localparam int BIT_ALL_ONES_ALARM  = 6;
  localparam int BIT_SLOT16_ALARM    = 5;
  localparam int BIT_SIGNAL_LOST     = 4;
  localparam int BIT_AUX_PATTERN     = 3;
  localparam int BIT_MULTIFRAME      = 2;
  localparam int BIT_RECEIVE_SLIP    = 1;
  localparam int BIT_OVF_SYNC_LOSS   = 4;
  localparam int BIT_OVF_ALIGN_ERR   = 3;
  localparam int BIT_OVF_ERR_ALIGN   = 2;
  localparam int BIT_OVF_VIOLATION   = 1;
  localparam int BIT_OVF_CRC4        = 0;
  localparam int BIT_LONG_WINDOW     = 1;
  localparam int BIT_SUSTAINED       = 0;

  // ----------------------------------------------------------------
  // counter widths and reset values
  // ----------------------------------------------------------------
  localparam int SYNC_LOSS_WIDTH     = 8;
  localparam int ALIGN_ERR_WIDTH     = 8;
  localparam int ERR_ALIGN_WIDTH     = 8;
  localparam int VIOLATION_WIDTH     = 16;
  localparam int CRC4_WIDTH          = 10;
  localparam logic [7:0] RESET_BYTE  = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ            = 25000000;
  localparam int CLOCK_KHZ           = CLOCK_HZ / 1000;
  localparam int RAI_SHORT_MS        = 10;
  localparam int RAI_LONG_MS         = 450;
  localparam int RAI_SHORT_CYCLES    = RAI_SHORT_MS * CLOCK_KHZ;
  localparam int RAI_LONG_CYCLES     = RAI_LONG_MS * CLOCK_KHZ;

endpackage
`default_nettype wire

//--- logic/count_link.sv
`timescale 1ns/10ps
`default_nettype none
// counter request and value, between the monitor and one counter
interface count_link #(parameter int WIDTH = 8);
  logic             step;
  logic [3:0]       amount;
  logic             clear;
  logic [WIDTH-1:0] value;
  logic             wrapped;

  modport counter (input step, input amount, input clear,
                   output value, output wrapped);
  modport user    (output step, output amount, output clear,
                   input value, input wrapped);
endinterface
`default_nettype wire

//--- logic/event_counter.sv
`timescale 1ns/10ps
`default_nettype none
module event_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic    clock_in,
  input  wire logic    resetn_in,
  count_link.counter   link
);

  logic [WIDTH-1:0] value_reg;
  logic [WIDTH-1:0] value_next;
  logic [WIDTH:0]   sum;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (WIDTH < 4 || WIDTH > 24)
  begin : g_bad_width
    $error("event_counter width out of range");
  end

  // ----------------------------------------------------------------
  // next value
  // ----------------------------------------------------------------
  // wraps past the top value, keeping the low bits of the sum
  always_comb
  begin
    sum = {1'b0, value_reg} + {{(WIDTH-3){1'b0}}, link.amount};
    value_next = value_reg;
    if (link.clear)
    begin
      value_next = link.step ? {{(WIDTH-4){1'b0}}, link.amount}
                             : {WIDTH{1'b0}};
    end
    else if (link.step)
    begin
      value_next = sum[WIDTH-1:0];
    end
  end

  // overflow pulse in the cycle of the wrap
  assign link.wrapped = link.step && !link.clear && sum[WIDTH];
  assign link.value   = value_reg;

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      value_reg <= {WIDTH{1'b0}};
    else
      value_reg <= value_next;
  end

  a_count_wrap_zero: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (link.step && !link.clear && link.amount == 4'h1
     && value_reg == {WIDTH{1'b1}})
    |-> link.wrapped ##1 value_reg == {WIDTH{1'b0}})
    else $error("counter did not wrap to zero with overflow");

endmodule
`default_nettype wire

//--- logic/rai_crc_timer.sv
`timescale 1ns/10ps
`default_nettype none
module rai_crc_timer #(
  parameter int SHORT_CYCLES = 250000,
  parameter int LONG_CYCLES  = 11250000
) (
  input  wire logic clock_in,
  input  wire logic resetn_in,
  input  wire logic condition_in,
  input  wire logic read_clear_in,
  output logic      sustained_out,
  output logic      long_window_out
);

  localparam int CW = $clog2(LONG_CYCLES + 2);
  localparam logic [CW-1:0] SHORT_C = CW'(SHORT_CYCLES);
  localparam logic [CW-1:0] LONG_C  = CW'(LONG_CYCLES);

  logic [CW-1:0] run_reg;
  logic [CW-1:0] run_next;
  logic          sustained_reg;
  logic          sustained_next;
  logic          long_reg;
  logic          long_next;
  logic          run_ended;

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (SHORT_CYCLES < 1 || LONG_CYCLES <= SHORT_CYCLES)
  begin : g_bad_times
    $error("rai_crc_timer needs 1 <= short < long");
  end

  // ----------------------------------------------------------------
  // run length and flags
  // ----------------------------------------------------------------
  // run counter saturates just past the long limit
  always_comb
  begin
    run_ended = !condition_in && run_reg > SHORT_C && run_reg < LONG_C;
    run_next = run_reg;
    if (!condition_in)
      run_next = '0;
    else if (run_reg <= LONG_C)
      run_next = run_reg + CW'(1);
    sustained_next = condition_in && run_reg >= SHORT_C;
    // set wins over the read clear
    long_next = run_ended || (long_reg && !read_clear_in);
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      run_reg       <= '0;
      sustained_reg <= 1'b0;
      long_reg      <= 1'b0;
    end
    else
    begin
      run_reg       <= run_next;
      sustained_reg <= sustained_next;
      long_reg      <= long_next;
    end
  end

  assign sustained_out   = sustained_reg;
  assign long_window_out = long_reg;

  a_sustain_drops: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    !condition_in |=> !sustained_out)
    else $error("sustained flag high after condition broke");

  a_long_window_set: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (!condition_in && run_reg > SHORT_C && run_reg < LONG_C)
    |=> long_window_out)
    else $error("long window flag not set at end of run");

endmodule
`default_nettype wire

//--- logic/e1_receive_performance_monitor.sv
// Functional notes
// - count lost-sync frame periods, eight bits
// - clear that count on sync to loss
// - count total bit errors in alignment words
// - flag runs between 10 and 450 ms
// - status high while run exceeds 10 ms
// - count alignment words with any error
// - latch remote alarm, clear on read
// - latch all-ones alarm, clear on read
// - latch slot 16 all-ones, clear on read
// - latch loss of signal, clear on read
// - latch auxiliary pattern, clear on read
// - latch multiframe alarm, clear on read
// - latch elastic buffer slip, clear on read
// - sixteen-bit violation count, high then low byte
// - ten-bit crc-4 count over two bytes
// - overflow latch per counter, clear on read
`timescale 1ns/10ps
`default_nettype none
module e1_receive_performance_monitor
  import e1_pm_pkg::*;
#(
  parameter int RAI_SHORT = RAI_SHORT_CYCLES,
  parameter int RAI_LONG  = RAI_LONG_CYCLES
) (
  input  wire logic       clock_in,
  input  wire logic       resetn_in,
  input  wire logic       frame_tick_in,
  input  wire logic       sync_lost_in,
  input  wire logic       fas_checked_in,
  input  wire logic [3:0] fas_error_bits_in,
  input  wire logic       violation_in,
  input  wire logic       crc4_error_in,
  input  wire logic       a_bit_high_in,
  input  wire logic       e_bit_low_in,
  input  wire logic       remote_alarm_in,
  input  wire logic       all_ones_alarm_in,
  input  wire logic       slot16_all_ones_alarm_in,
  input  wire logic       signal_lost_in,
  input  wire logic       auxiliary_pattern_alarm_in,
  input  wire logic       multiframe_alarm_flag_in,
  input  wire logic       receive_slip_flag_in,
  input  wire logic [4:0] addr_in,
  input  wire logic       read_in,
  output logic [7:0]      read_data_out,
  output logic            read_valid_out
);

  // ----------------------------------------------------------------
  // local state
  // ----------------------------------------------------------------
  logic       sync_prev_reg;
  logic       sync_prev_next;
  logic [7:0] alarm_reg;
  logic [7:0] alarm_next;
  logic [7:0] alarm_set;
  logic [7:0] overflow_reg;
  logic [7:0] overflow_next;
  logic [7:0] overflow_set;
  logic [7:0] read_data_reg;
  logic [7:0] read_data_next;
  logic       read_valid_reg;
  logic       read_valid_next;
  logic       sustained_flag;
  logic       long_window_flag;
  logic       rai_crc_read;

  // decode of a read at one offset
  function automatic logic read_hit(input logic       rd,
                                    input logic [4:0] a,
                                    input logic [4:0] offset);
    return rd && (a == offset);
  endfunction

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  count_link #(.WIDTH(SYNC_LOSS_WIDTH)) sync_loss_link ();
  count_link #(.WIDTH(ALIGN_ERR_WIDTH)) align_err_link ();
  count_link #(.WIDTH(ERR_ALIGN_WIDTH)) err_align_link ();
  count_link #(.WIDTH(VIOLATION_WIDTH)) violation_link ();
  count_link #(.WIDTH(CRC4_WIDTH))      crc4_link ();

  // one step per frame period without alignment
  assign sync_loss_link.step   = frame_tick_in && sync_lost_in;
  assign sync_loss_link.amount = 4'h1;
  // restart on entering the lost state
  assign sync_loss_link.clear  = sync_lost_in && !sync_prev_reg;

  // errored bits of each checked alignment word
  assign align_err_link.step   = fas_checked_in;
  assign align_err_link.amount = fas_error_bits_in;
  assign align_err_link.clear  = 1'b0;

  // one per errored word, whatever the bit count
  assign err_align_link.step   = fas_checked_in
                                 && fas_error_bits_in != 4'h0;
  assign err_align_link.amount = 4'h1;
  assign err_align_link.clear  = 1'b0;

  // violation and crc-4 events
  assign violation_link.step   = violation_in;
  assign violation_link.amount = 4'h1;
  assign violation_link.clear  = 1'b0;
  assign crc4_link.step        = crc4_error_in;
  assign crc4_link.amount      = 4'h1;
  assign crc4_link.clear       = 1'b0;

  event_counter #(.WIDTH(SYNC_LOSS_WIDTH)) u_sync_loss_count (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .link      (sync_loss_link.counter)
  );

  event_counter #(.WIDTH(ALIGN_ERR_WIDTH)) u_align_err_count (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .link      (align_err_link.counter)
  );

  event_counter #(.WIDTH(ERR_ALIGN_WIDTH)) u_err_align_count (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .link      (err_align_link.counter)
  );

  event_counter #(.WIDTH(VIOLATION_WIDTH)) u_violation_count (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .link      (violation_link.counter)
  );

  event_counter #(.WIDTH(CRC4_WIDTH)) u_crc4_count (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .link      (crc4_link.counter)
  );

  // ----------------------------------------------------------------
  // remote alarm with crc error timing
  // ----------------------------------------------------------------
  assign rai_crc_read = read_hit(read_in, addr_in, OFS_RAI_CRC_FLAGS);

  rai_crc_timer #(
    .SHORT_CYCLES (RAI_SHORT),
    .LONG_CYCLES  (RAI_LONG)
  ) u_rai_crc_timer (
    .clock_in        (clock_in),
    .resetn_in       (resetn_in),
    .condition_in    (a_bit_high_in && e_bit_low_in),
    .read_clear_in   (rai_crc_read),
    .sustained_out   (sustained_flag),
    .long_window_out (long_window_flag)
  );

  // ----------------------------------------------------------------
  // latches and read port
  // ----------------------------------------------------------------
  // event sources of each latch
  always_comb
  begin
    alarm_set = 8'h00;
    alarm_set[BIT_REMOTE_ALARM]   = remote_alarm_in;
    alarm_set[BIT_ALL_ONES_ALARM] = all_ones_alarm_in;
    alarm_set[BIT_SLOT16_ALARM]   = slot16_all_ones_alarm_in;
    alarm_set[BIT_SIGNAL_LOST]    = signal_lost_in;
    alarm_set[BIT_AUX_PATTERN]    = auxiliary_pattern_alarm_in;
    alarm_set[BIT_MULTIFRAME]     = multiframe_alarm_flag_in;
    alarm_set[BIT_RECEIVE_SLIP]   = receive_slip_flag_in;
    overflow_set = 8'h00;
    overflow_set[BIT_OVF_SYNC_LOSS] = sync_loss_link.wrapped;
    overflow_set[BIT_OVF_ALIGN_ERR] = align_err_link.wrapped;
    overflow_set[BIT_OVF_ERR_ALIGN] = err_align_link.wrapped;
    overflow_set[BIT_OVF_VIOLATION] = violation_link.wrapped;
    overflow_set[BIT_OVF_CRC4]      = crc4_link.wrapped;
  end

  // next state, a set in the clearing cycle wins
  always_comb
  begin
    sync_prev_next = sync_lost_in;
    alarm_next     = alarm_set;
    overflow_next  = overflow_set;
    if (!read_hit(read_in, addr_in, OFS_ALARM_LATCH))
      alarm_next = alarm_reg | alarm_set;
    if (!read_hit(read_in, addr_in, OFS_OVERFLOW_LATCH))
      overflow_next = overflow_reg | overflow_set;
    read_valid_next = read_in;
    read_data_next  = read_data_reg;
    if (read_in)
    begin
      unique case (addr_in)
        OFS_OVERFLOW_LATCH:  read_data_next = overflow_reg;
        OFS_LOST_SYNC_COUNT: read_data_next = sync_loss_link.value;
        OFS_ALIGN_BIT_COUNT: read_data_next = align_err_link.value;
        OFS_RAI_CRC_FLAGS:   read_data_next = {6'h00, long_window_flag,
                                               sustained_flag};
        OFS_ERR_ALIGN_COUNT: read_data_next = err_align_link.value;
        OFS_ALARM_LATCH:     read_data_next = {alarm_reg[7:1],
                                               1'b0};
        OFS_VIOLATION_HIGH:  read_data_next =
                               violation_link.value[15:8];
        OFS_VIOLATION_LOW:   read_data_next =
                               violation_link.value[7:0];
        OFS_CRC4_HIGH:       read_data_next = {6'h00,
                               crc4_link.value[9:8]};
        OFS_CRC4_LOW:        read_data_next =
                               crc4_link.value[7:0];
        default:             read_data_next = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sync_prev_reg  <= 1'b0;
      alarm_reg      <= RESET_BYTE;
      overflow_reg   <= RESET_BYTE;
      read_data_reg  <= RESET_BYTE;
      read_valid_reg <= 1'b0;
    end
    else
    begin
      sync_prev_reg  <= sync_prev_next;
      alarm_reg      <= alarm_next;
      overflow_reg   <= overflow_next;
      read_data_reg  <= read_data_next;
      read_valid_reg <= read_valid_next;
    end
  end

  assign read_data_out  = read_data_reg;
  assign read_valid_out = read_valid_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sync_loss_step: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (frame_tick_in && sync_lost_in && sync_prev_reg
     && sync_loss_link.value != 8'hff)
    |=> sync_loss_link.value == $past(sync_loss_link.value) + 8'h01)
    else $error("lost sync count did not step per frame");

  a_sync_loss_clear: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (sync_lost_in && !sync_prev_reg && !frame_tick_in)
    |=> sync_loss_link.value == 8'h00)
    else $error("lost sync count not cleared on entry");

  a_align_bit_total: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (fas_checked_in && align_err_link.value <= 8'hf0)
    |=> align_err_link.value
        == $past(align_err_link.value) + {4'h0, $past(fas_error_bits_in)})
    else $error("alignment bit total wrong");

  a_errored_word_once: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (fas_checked_in && fas_error_bits_in != 4'h0
     && err_align_link.value != 8'hff)
    |=> err_align_link.value == $past(err_align_link.value) + 8'h01)
    else $error("errored word not counted exactly once");

  a_remote_alarm_latch: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    remote_alarm_in |=> alarm_reg[BIT_REMOTE_ALARM])
    else $error("remote alarm not latched");

  a_alarm_read_clear: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (read_in && addr_in == OFS_ALARM_LATCH && alarm_set == 8'h00)
    |=> alarm_reg == 8'h00 && read_data_out == $past(alarm_reg))
    else $error("alarm latch not cleared by read");

  a_unused_zero: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (read_in && (addr_in == OFS_RAI_CRC_FLAGS
                 || addr_in == OFS_CRC4_HIGH))
    |=> read_valid_out && read_data_out[7:2] == 6'h00)
    else $error("unused bits read non-zero");

  a_violation_overflow: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    violation_link.wrapped
    |=> overflow_reg[BIT_OVF_VIOLATION] && violation_link.value == 16'h0000)
    else $error("violation overflow not latched");

  a_overflow_read_clear: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (read_in && addr_in == OFS_OVERFLOW_LATCH && overflow_set == 8'h00)
    |=> overflow_reg == 8'h00 && read_data_out == $past(overflow_reg))
    else $error("overflow latch not cleared by read");

  a_slip_latch: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    receive_slip_flag_in |=> alarm_reg[BIT_RECEIVE_SLIP])
    else $error("receive slip not latched");

  a_alarm_bit_zero: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    (read_in && addr_in == OFS_ALARM_LATCH)
    |=> read_valid_out && !read_data_out[0])
    else $error("unused alarm latch bit read non-zero");

endmodule
`default_nettype wire

//--- testbench/framer_rx_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// receive framer stand-in: event pulses and alarm levels
// ----------------------------------------------------------------
module framer_rx_model (
  input  wire logic   clock_in,
  output logic [10:0] events_out,
  output logic [3:0]  fas_bits_out,
  output logic        sync_lost_out,
  output logic        a_high_out,
  output logic        e_low_out
);
  // idle state, error count lines carry junk while unqualified
  initial
  begin
    events_out    = 11'h000;
    fas_bits_out  = 4'hf;
    sync_lost_out = 1'b0;
    a_high_out    = 1'b0;
    e_low_out     = 1'b0;
  end

  // one-cycle burst of events, then the count lines flip
  task automatic pulse(input logic [10:0] mask, input logic [3:0] bits);
    @(posedge clock_in);
    #1;
    events_out   = mask;
    fas_bits_out = bits;
    @(posedge clock_in);
    #1;
    events_out   = 11'h000;
    fas_bits_out = ~bits;
  endtask

  // change the level conditions just after an edge
  task automatic level(input logic s, input logic a, input logic e);
    @(posedge clock_in);
    #1;
    sync_lost_out = s;
    a_high_out    = a;
    e_low_out     = e;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb_e1_receive_performance_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module tb_e1_receive_performance_monitor
  import e1_pm_pkg::*;
;
  logic        clock_in;
  logic        resetn;
  logic        read;
  logic [4:0]  addr;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [10:0] ev;
  logic [3:0]  fbits;
  logic        sl;
  logic        ah;
  logic        el;
  int          mismatches;
  int          samples_checked;
  int          cycles;

  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  e1_receive_performance_monitor #(.RAI_SHORT(20), .RAI_LONG(100))
    e1_receive_performance_monitor_i (
    .clock_in                   (clock_in),
    .resetn_in                  (resetn),
    .frame_tick_in              (ev[0]),
    .sync_lost_in               (sl),
    .fas_checked_in             (ev[1]),
    .fas_error_bits_in          (fbits),
    .violation_in               (ev[2]),
    .crc4_error_in              (ev[3]),
    .a_bit_high_in              (ah),
    .e_bit_low_in               (el),
    .remote_alarm_in            (ev[10]),
    .all_ones_alarm_in          (ev[9]),
    .slot16_all_ones_alarm_in   (ev[8]),
    .signal_lost_in             (ev[7]),
    .auxiliary_pattern_alarm_in (ev[6]),
    .multiframe_alarm_flag_in   (ev[5]),
    .receive_slip_flag_in       (ev[4]),
    .addr_in                    (addr),
    .read_in                    (read),
    .read_data_out              (rdata),
    .read_valid_out             (rvalid)
  );

  framer_rx_model framer_rx_model_i (
    .clock_in      (clock_in),
    .events_out    (ev),
    .fas_bits_out  (fbits),
    .sync_lost_out (sl),
    .a_high_out    (ah),
    .e_low_out     (el)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one register read, answer one cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    #1;
    read = 1'b1;
    addr = a;
    @(posedge clock_in);
    #1;
    read = 1'b0;
    addr = ~a;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    for (int a = 5'h16; a <= 5'h1f; a++)
      rd(a[4:0], 8'h00);
    rd(5'h00, 8'h00);
    rd(5'h15, 8'h00);
  endtask

  task automatic test_counts;
    repeat (300) framer_rx_model_i.pulse(11'h004, 4'h0);
    repeat (260) framer_rx_model_i.pulse(11'h008, 4'h0);
    rd(OFS_VIOLATION_HIGH, 8'h01);
    rd(OFS_VIOLATION_LOW, 8'h2c);
    rd(OFS_CRC4_HIGH, 8'h01);
    rd(OFS_CRC4_LOW, 8'h04);
  endtask

  task automatic test_sync_loss;
    framer_rx_model_i.level(1'b1, 1'b0, 1'b0);
    repeat (3) framer_rx_model_i.pulse(11'h001, 4'h0);
    rd(OFS_LOST_SYNC_COUNT, 8'h03);
    framer_rx_model_i.level(1'b0, 1'b0, 1'b0);
    framer_rx_model_i.pulse(11'h001, 4'h0);
    rd(OFS_LOST_SYNC_COUNT, 8'h03);
    framer_rx_model_i.level(1'b1, 1'b0, 1'b0);
    rd(OFS_LOST_SYNC_COUNT, 8'h00);
    framer_rx_model_i.level(1'b0, 1'b0, 1'b0);
    // entry into loss with a frame tick in the same cycle loads one
    fork
      framer_rx_model_i.level(1'b1, 1'b0, 1'b0);
      framer_rx_model_i.pulse(11'h001, 4'h0);
    join
    rd(OFS_LOST_SYNC_COUNT, 8'h01);
    framer_rx_model_i.level(1'b0, 1'b0, 1'b0);
  endtask

  task automatic test_alignment;
    framer_rx_model_i.pulse(11'h002, 4'h0);
    framer_rx_model_i.pulse(11'h002, 4'h3);
    framer_rx_model_i.pulse(11'h002, 4'h1);
    rd(OFS_ALIGN_BIT_COUNT, 8'h04);
    rd(OFS_ERR_ALIGN_COUNT, 8'h02);
  endtask

  // each alarm alone, then the latch reads clear
  task automatic test_alarms;
    for (int b = 1; b < 8; b++)
    begin
      framer_rx_model_i.pulse(11'h001 << (b + 3), 4'h0);
      rd(OFS_ALARM_LATCH, 8'h01 << b);
      rd(OFS_ALARM_LATCH, 8'h00);
    end
    // a slip in the clearing cycle survives the read
    fork
      framer_rx_model_i.pulse(11'h010, 4'h0);
      rd(OFS_ALARM_LATCH, 8'h00);
    join
    rd(OFS_ALARM_LATCH, 8'h02);
    rd(OFS_ALARM_LATCH, 8'h00);
  endtask

  task automatic test_remote_crc;
    framer_rx_model_i.level(1'b0, 1'b1, 1'b1);
    repeat (30) @(posedge clock_in);
    rd(OFS_RAI_CRC_FLAGS, 8'h01);
    framer_rx_model_i.level(1'b0, 1'b0, 1'b1);
    repeat (2) @(posedge clock_in);
    rd(OFS_RAI_CRC_FLAGS, 8'h02);
    rd(OFS_RAI_CRC_FLAGS, 8'h00);
    framer_rx_model_i.level(1'b0, 1'b1, 1'b1);
    repeat (120) @(posedge clock_in);
    rd(OFS_RAI_CRC_FLAGS, 8'h01);
    framer_rx_model_i.level(1'b0, 1'b1, 1'b0);
    repeat (2) @(posedge clock_in);
    rd(OFS_RAI_CRC_FLAGS, 8'h00);
  endtask

  // both alignment counters pass their top value
  task automatic test_overflow;
    repeat (254) framer_rx_model_i.pulse(11'h002, 4'h1);
    rd(OFS_ALIGN_BIT_COUNT, 8'h02);
    rd(OFS_ERR_ALIGN_COUNT, 8'h00);
    rd(OFS_OVERFLOW_LATCH, 8'h0c);
    rd(OFS_OVERFLOW_LATCH, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // clock, reset, sequence and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end

  initial
  begin
    mismatches      = 0;
    samples_checked = 0;
    cycles          = 0;
    resetn          = 1'b0;
    read            = 1'b0;
    addr            = 5'h00;
    repeat (4) @(posedge clock_in);
    #1;
    resetn = 1'b1;
    test_reset();
    test_counts();
    test_sync_loss();
    test_alignment();
    test_alarms();
    test_remote_crc();
    test_overflow();
    complete_run();
  end
endmodule
`default_nettype wire
